// file: logic/cntarr_map.svh
// Functional notes
// - Counter low byte readable, writable, resets zero.
// - Counter high byte separate register, resets zero.
// - High byte reads snapshot, refreshed on low read.
// - Watchdog enabled blocks counter byte writes.
// - Three capture modules, low/high bytes, reset zero.
// - Low capture address reaches reload low by select.
// - High capture address reaches reload high by select.
// - Low capture write clears compare enable.
// - High capture write sets compare enable.
// - Compare enable is the comparator enable bit.
`ifndef CNTARR_MAP_SVH
`define CNTARR_MAP_SVH
`define CNTARR_ADDR_CAP1_LOW 8'he9
`define CNTARR_ADDR_CAP1_HIGH 8'hea
`define CNTARR_ADDR_CAP2_LOW 8'heb
`define CNTARR_ADDR_CAP2_HIGH 8'hec
`define CNTARR_ADDR_CNT_LOW 8'hf9
`define CNTARR_ADDR_CNT_HIGH 8'hfa
`define CNTARR_ADDR_CAP0_LOW 8'hfb
`define CNTARR_ADDR_CAP0_HIGH 8'hfc
`define CNTARR_BYTE_RESET 8'h00
`define CNTARR_WORD_RESET 16'h0000
`define CNTARR_READ_IDLE 8'h00
`define CNTARR_CNT_STEP 16'h0001
`endif

// file: logic/cntarr_pkg.sv
package cntarr_pkg;
  typedef logic [7:0] cntarr_byte_t;
  typedef logic [15:0] cntarr_word_t;
endpackage

// file: logic/cntarr_channel.sv
`include "cntarr_map.svh"
`timescale 1ns/1ns
`default_nettype none
module cntarr_channel #(
  parameter logic [7:0] ADDR_LOW = 8'h00,
  parameter logic [7:0] ADDR_HIGH = 8'h00
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Register access.
  input wire logic wr_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic reload_sel_in,
  input wire logic enable_wr_in,
  input wire logic enable_val_in,
  // State out.
  output logic [15:0] capture_out,
  output logic [15:0] reload_out,
  output logic compare_enable_out,
  output logic [7:0] low_read_out,
  output logic [7:0] high_read_out
);
  logic wr_low;
  logic wr_high;
  assign wr_low = wr_in && (addr_in == ADDR_LOW);
  assign wr_high = wr_in && (addr_in == ADDR_HIGH);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      capture_out <= `CNTARR_WORD_RESET;
    end else begin
      if (wr_low && !reload_sel_in) begin
        capture_out[7:0] <= wdata_in;
      end
      if (wr_high && !reload_sel_in) begin
        capture_out[15:8] <= wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reload_out <= `CNTARR_WORD_RESET;
    end else begin
      if (wr_low && reload_sel_in) begin
        reload_out[7:0] <= wdata_in;
      end
      if (wr_high && reload_sel_in) begin
        reload_out[15:8] <= wdata_in;
      end
    end
  end

  // A capture-byte write wins over a mode-register write in the same cycle.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      compare_enable_out <= 1'b0;
    end else if (wr_high) begin
      compare_enable_out <= 1'b1;
    end else if (wr_low) begin
      compare_enable_out <= 1'b0;
    end else if (enable_wr_in) begin
      compare_enable_out <= enable_val_in;
    end
  end

  assign low_read_out = reload_sel_in ? reload_out[7:0] : capture_out[7:0];
  assign high_read_out = reload_sel_in ? reload_out[15:8] : capture_out[15:8];
endmodule // cntarr_channel
`default_nettype wire

// file: logic/cntarr_top.sv
`include "cntarr_map.svh"
`timescale 1ns/1ns
`default_nettype none
module cntarr_top (
  // Clock and reset.
  input wire logic CLK_SYS_IN,
  input wire logic RESETN_IN,
  // Special-function register access.
  input wire logic SFR_WR_IN,
  input wire logic SFR_RD_IN,
  input wire logic [7:0] SFR_ADDR_IN,
  input wire logic [7:0] SFR_WDATA_IN,
  output logic [7:0] SFR_RDATA_OUT,
  // Control from the mode and watchdog logic.
  input wire logic WATCHDOG_ENABLE_BIT_IN,
  input wire logic AUTO_RELOAD_SELECT_IN,
  input wire logic COUNT_TICK_IN,
  input wire logic [2:0] COMPARE_ENABLE_WR_IN,
  input wire logic [2:0] COMPARE_ENABLE_VAL_IN,
  // State out.
  output logic [15:0] ARRAY_COUNTER_VALUE_OUT,
  output logic [47:0] CAPTURE_VALUE_OUT,
  output logic [47:0] RELOAD_VALUE_OUT,
  output logic [2:0] COMPARE_ENABLE_OUT
);
  localparam logic [7:0] ADDR_LOW [3] = '{`CNTARR_ADDR_CAP0_LOW,
    `CNTARR_ADDR_CAP1_LOW, `CNTARR_ADDR_CAP2_LOW};
  localparam logic [7:0] ADDR_HIGH [3] = '{`CNTARR_ADDR_CAP0_HIGH,
    `CNTARR_ADDR_CAP1_HIGH, `CNTARR_ADDR_CAP2_HIGH};

  logic [1:0] rst_sync_q;
  logic rst_n;
  cntarr_pkg::cntarr_word_t counter_q;
  cntarr_pkg::cntarr_byte_t snapshot_q;
  cntarr_pkg::cntarr_byte_t rdata_d;
  cntarr_pkg::cntarr_byte_t rdata_q;
  logic [7:0] low_rd [3];
  logic [7:0] high_rd [3];
  logic wr_cnt_low;
  logic wr_cnt_high;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Software must clear the watchdog enable first; writes meanwhile vanish.
  assign wr_cnt_low = SFR_WR_IN && (SFR_ADDR_IN == `CNTARR_ADDR_CNT_LOW) &&
    !WATCHDOG_ENABLE_BIT_IN;
  assign wr_cnt_high = SFR_WR_IN && (SFR_ADDR_IN == `CNTARR_ADDR_CNT_HIGH) &&
    !WATCHDOG_ENABLE_BIT_IN;

  // A software load takes priority over the tick in the same cycle.
  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      counter_q <= `CNTARR_WORD_RESET;
    end else begin
      if (wr_cnt_low || wr_cnt_high) begin
        if (wr_cnt_low) begin
          counter_q[7:0] <= SFR_WDATA_IN;
        end
        if (wr_cnt_high) begin
          counter_q[15:8] <= SFR_WDATA_IN;
        end
      end else if (COUNT_TICK_IN) begin
        counter_q <= counter_q + `CNTARR_CNT_STEP;
      end
    end
  end

  // The snapshot keeps a low-then-high read pair coherent while counting.
  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      snapshot_q <= `CNTARR_BYTE_RESET;
    end else if (SFR_RD_IN && (SFR_ADDR_IN == `CNTARR_ADDR_CNT_LOW)) begin
      snapshot_q <= counter_q[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  for (genvar i = 0; i < 3; i++) begin : g_chan
    cntarr_channel #(
      .ADDR_LOW(ADDR_LOW[i]),
      .ADDR_HIGH(ADDR_HIGH[i])
    ) u_chan (
      .clk_in(CLK_SYS_IN),
      .rst_n_in(rst_n),
      .wr_in(SFR_WR_IN),
      .addr_in(SFR_ADDR_IN),
      .wdata_in(SFR_WDATA_IN),
      .reload_sel_in(AUTO_RELOAD_SELECT_IN),
      .enable_wr_in(COMPARE_ENABLE_WR_IN[i]),
      .enable_val_in(COMPARE_ENABLE_VAL_IN[i]),
      .capture_out(CAPTURE_VALUE_OUT[i*16 +: 16]),
      .reload_out(RELOAD_VALUE_OUT[i*16 +: 16]),
      .compare_enable_out(COMPARE_ENABLE_OUT[i]),
      .low_read_out(low_rd[i]),
      .high_read_out(high_rd[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rdata_d = `CNTARR_READ_IDLE;
    if (SFR_RD_IN) begin
      unique case (SFR_ADDR_IN)
        `CNTARR_ADDR_CNT_LOW: rdata_d = counter_q[7:0];
        `CNTARR_ADDR_CNT_HIGH: rdata_d = snapshot_q;
        `CNTARR_ADDR_CAP0_LOW: rdata_d = low_rd[0];
        `CNTARR_ADDR_CAP0_HIGH: rdata_d = high_rd[0];
        `CNTARR_ADDR_CAP1_LOW: rdata_d = low_rd[1];
        `CNTARR_ADDR_CAP1_HIGH: rdata_d = high_rd[1];
        `CNTARR_ADDR_CAP2_LOW: rdata_d = low_rd[2];
        `CNTARR_ADDR_CAP2_HIGH: rdata_d = high_rd[2];
        default: rdata_d = `CNTARR_READ_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= `CNTARR_BYTE_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign SFR_RDATA_OUT = rdata_q;
  assign ARRAY_COUNTER_VALUE_OUT = counter_q;
endmodule // cntarr_top
`default_nettype wire

// file: tb/cntarr_sva.sv
`timescale 1ns/1ns
`default_nettype none
module cntarr_sva (
  // Clock, reset and access.
  input wire logic CLK_SYS_IN,
  input wire logic RESETN_IN,
  input wire logic SFR_WR_IN,
  input wire logic SFR_RD_IN,
  input wire logic [7:0] SFR_ADDR_IN,
  input wire logic [7:0] SFR_WDATA_IN,
  input wire logic [7:0] SFR_RDATA_OUT,
  // Control and state.
  input wire logic WATCHDOG_ENABLE_BIT_IN,
  input wire logic AUTO_RELOAD_SELECT_IN,
  input wire logic COUNT_TICK_IN,
  input wire logic [15:0] ARRAY_COUNTER_VALUE_OUT,
  input wire logic [47:0] CAPTURE_VALUE_OUT,
  input wire logic [47:0] RELOAD_VALUE_OUT,
  input wire logic [2:0] COMPARE_ENABLE_OUT
);
  wire logic [7:0] ad = SFR_ADDR_IN;
  wire logic w = SFR_WR_IN;
  wire logic r = SFR_RD_IN;
  wire logic [15:0] cnt = ARRAY_COUNTER_VALUE_OUT;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESETN_IN);
  ////////////////////////////////////////
  a_low_clears_enable: assert property (w && ad == 8'hfb |=> !COMPARE_ENABLE_OUT[0])
    else $error("enable kept after low write");
  a_high_sets_enable: assert property (w && ad == 8'hea |=> COMPARE_ENABLE_OUT[1])
    else $error("enable not set after high write");
  a_counter_low_load: assert property (w && ad == 8'hf9 && !WATCHDOG_ENABLE_BIT_IN
    |=> cnt[7:0] == $past(SFR_WDATA_IN)) else $error("counter low not loaded");
  a_watchdog_lock: assert property (w && ad[7:1] == 7'h7c && ad[0] && WATCHDOG_ENABLE_BIT_IN
    && !COUNT_TICK_IN |=> $stable(cnt)) else $error("locked counter changed");
  a_low_read_live: assert property (r && ad == 8'hf9 |=> SFR_RDATA_OUT == $past(cnt[7:0]))
    else $error("low read wrong");
  a_high_snapshot: assert property (r && ad == 8'hf9 ##1 r && ad == 8'hfa
    |=> SFR_RDATA_OUT == $past(cnt[15:8], 2)) else $error("snapshot wrong");
  a_capture_low: assert property (w && ad == 8'hfb && !AUTO_RELOAD_SELECT_IN
    |=> CAPTURE_VALUE_OUT[7:0] == $past(SFR_WDATA_IN)) else $error("capture low wrong");
  a_reload_high: assert property (w && ad == 8'hec && AUTO_RELOAD_SELECT_IN
    |=> RELOAD_VALUE_OUT[47:40] == $past(SFR_WDATA_IN)) else $error("reload high wrong");
endmodule // cntarr_sva
bind cntarr_top cntarr_sva cntarr_sva_i (.*);
`default_nettype wire

// file: tb/counter_array_register_access_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module counter_array_register_access_tb_top;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, wd = 0, ars = 0, tick = 0;
  logic [7:0] a = 8'h00, d = 8'h00, rdata;
  logic [15:0] cnt;
  logic [47:0] cap, rel;
  logic [2:0] ce;
  logic [2:0] cew = 3'h0, cev = 3'h0;
  int error_cnt = 0, n_compared = 0;
  always #25 clk = ~clk;
  cntarr_top cntarr_top_i (.CLK_SYS_IN(clk), .RESETN_IN(rstn), .SFR_WR_IN(wr),
    .SFR_RD_IN(rd), .SFR_ADDR_IN(a), .SFR_WDATA_IN(d), .SFR_RDATA_OUT(rdata),
    .WATCHDOG_ENABLE_BIT_IN(wd), .AUTO_RELOAD_SELECT_IN(ars), .COUNT_TICK_IN(tick),
    .COMPARE_ENABLE_WR_IN(cew), .COMPARE_ENABLE_VAL_IN(cev),
    .ARRAY_COUNTER_VALUE_OUT(cnt), .CAPTURE_VALUE_OUT(cap),
    .RELOAD_VALUE_OUT(rel), .COMPARE_ENABLE_OUT(ce));
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [47:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Strobes stay up until the next call, so reads can run back to back.
  task automatic acc(input logic w, r, input logic [7:0] ad, dt);
    wr = w; rd = r; a = ad; d = dt;
    @(posedge clk);
    #1;
  endtask
  task automatic rdchk(input logic [7:0] ad, e);
    acc(1'b0, 1'b1, ad, 8'h00);
    chk("read data", rdata, e);
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] m [8] = '{8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'he9, 8'hea, 8'heb, 8'hec};
    foreach (m[i]) rdchk(m[i], 8'h00);
    chk("enables", ce, 3'h0);
    $display("reset test done");
  endtask
  task automatic t_counter;
    acc(1'b1, 1'b0, 8'hf9, 8'hff);
    acc(1'b1, 1'b0, 8'hfa, 8'h12);
    chk("counter", cnt, 16'h12ff);
    tick = 1'b1;
    acc(1'b0, 1'b0, 8'h00, 8'h00);
    tick = 1'b0;
    rdchk(8'hf9, 8'h00);
    rdchk(8'hfa, 8'h13);
    acc(1'b1, 1'b0, 8'hfa, 8'h77);
    rdchk(8'hfa, 8'h13);
    chk("counter", cnt, 16'h7700);
    $display("counter test done");
  endtask
  task automatic t_watchdog;
    wd = 1'b1;
    acc(1'b1, 1'b0, 8'hf9, 8'h55);
    acc(1'b1, 1'b0, 8'hfa, 8'h66);
    chk("locked counter", cnt, 16'h7700);
    wd = 1'b0;
    $display("watchdog test done");
  endtask
  task automatic t_capture;
    logic [7:0] lo [3] = '{8'hfb, 8'he9, 8'heb};
    for (logic [7:0] i = 0; i < 3; i++) begin
      ars = 1'b0;
      acc(1'b1, 1'b0, lo[i] + 8'h01, 8'ha0 + i);
      chk("enable", ce[i], 1'b1);
      acc(1'b1, 1'b0, lo[i], 8'h50 + i);
      chk("enable", ce[i], 1'b0);
      ars = 1'b1;
      acc(1'b1, 1'b0, lo[i], 8'hc0 + i);
      acc(1'b1, 1'b0, lo[i] + 8'h01, 8'hd0 + i);
      chk("enable", ce[i], 1'b1);
      chk("reload", rel[16*i+:16], {8'hd0 + i, 8'hc0 + i});
      chk("capture", cap[16*i+:16], {8'ha0 + i, 8'h50 + i});
      rdchk(lo[i], 8'hc0 + i);
      ars = 1'b0;
      rdchk(lo[i] + 8'h01, 8'ha0 + i);
    end
    $display("capture test done");
  endtask
  // A capture-byte write must win over a mode-register load in the same cycle.
  task automatic t_mode;
    cew = 3'h7;
    cev = 3'h0;
    acc(1'b0, 1'b0, 8'h00, 8'h00);
    chk("mode load", ce, 3'h0);
    acc(1'b1, 1'b0, 8'hfc, 8'h3c);
    chk("write beats mode", ce, 3'h1);
    cev = 3'h7;
    acc(1'b1, 1'b0, 8'he9, 8'h5a);
    chk("write beats mode", ce, 3'h5);
    cew = 3'h0;
    rdchk(8'hfc, 8'h3c);
    acc(1'b0, 1'b0, 8'h00, 8'h00);
    chk("read idle", rdata, 8'h00);
    rdchk(8'hfd, 8'h00);
    $display("mode test done");
  endtask
  task automatic t_midreset;
    rstn = 1'b0;
    acc(1'b0, 1'b0, 8'h00, 8'h00);
    chk("reset counter", cnt, 16'h0000);
    chk("reset capture", cap, 48'h0);
    chk("reset reload", rel, 48'h0);
    chk("reset enables", ce, 3'h0);
    rstn = 1'b1;
    repeat (3) acc(1'b0, 1'b0, 8'h00, 8'h00);
    rdchk(8'hfa, 8'h00);
    $display("mid-run reset test done");
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_reset;
    t_counter;
    t_watchdog;
    t_capture;
    t_mode;
    t_midreset;
    acc(1'b0, 1'b0, 8'h00, 8'h00);
    report_and_stop;
  end
  // The tests need under a hundred cycles, so this limit leaves wide margin.
  initial begin
    #20000;
    error_cnt++;
    report_and_stop;
  end
endmodule // counter_array_register_access_tb_top
`default_nettype wire
